// [logic/dsg_pkg.sv]
// Package for the deep-sleep clock gating register block.
// Assumes a single 32-bit AHB-Lite slave on one system clock.
package dsg_pkg;

	// Register offsets (byte addresses within the system control window).
	localparam logic [11:0] DSG_OFF_RUN = 12'h104;
	localparam logic [11:0] DSG_OFF_SLEEP = 12'h114;
	localparam logic [11:0] DSG_OFF_DEEP = 12'h124;
	localparam logic [11:0] DSG_OFF_MODE = 12'h060;
	localparam logic [31:0] DSG_BASE = 32'h400fe000;

	// Writable gate bits; every other bit is reserved and reads zero.
	localparam logic [31:0] DSG_GATE_MASK = 32'h07071117;
	localparam logic [31:0] DSG_GATE_RESET = 32'h00000000;

	// Bit positions of the gate enables.
	localparam int DSG_BIT_CMP2 = 26;
	localparam int DSG_BIT_CMP1 = 25;
	localparam int DSG_BIT_CMP0 = 24;
	localparam int DSG_BIT_TMR2 = 18;
	localparam int DSG_BIT_TMR1 = 17;
	localparam int DSG_BIT_TMR0 = 16;
	localparam int DSG_BIT_TWP = 12;
	localparam int DSG_BIT_ENC = 8;
	localparam int DSG_BIT_SSP = 4;
	localparam int DSG_BIT_SER2 = 2;
	localparam int DSG_BIT_SER1 = 1;
	localparam int DSG_BIT_SER0 = 0;

	// Mode register field: the auto gating select bit only.
	localparam int DSG_BIT_AUTO = 27;
	localparam logic [31:0] DSG_MODE_MASK = 32'h08000000;

	// Power modes that choose which gate set applies.
	typedef enum logic [2:0] {
		DSG_PM_RUN = 3'b001,
		DSG_PM_SLEEP = 3'b010,
		DSG_PM_DEEP = 3'b100
	} dsg_pm_e;

	// Captured address phase of an AHB-Lite transfer.
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] offset;
	} dsg_aphase_s;

endpackage

// [logic/dsg_gate_sel.sv]
// Selects which gate set drives the unit clock enables.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dsg_gate_sel (
	input wire logic auto_gating_select,
	input wire dsg_pkg::dsg_pm_e mode,
	input wire logic [31:0] run_gate,
	input wire logic [31:0] sleep_gate,
	input wire logic [31:0] deep_gate,
	output logic [31:0] gate
);

	// Sleep and deep sets apply only with auto gating; else run set.
	always_comb begin
		gate = run_gate;
		if (auto_gating_select) begin
			unique case (mode)
				dsg_pkg::DSG_PM_RUN: gate = run_gate;
				dsg_pkg::DSG_PM_SLEEP: gate = sleep_gate;
				dsg_pkg::DSG_PM_DEEP: gate = deep_gate;
				default: gate = run_gate;
			endcase
		end
	end

endmodule
`default_nettype wire

// [logic/dsg_top.sv]
// Deep-sleep clock gating register with its run and sleep companions.
// Assumes an AHB-Lite master on clk_sys and a power manager giving mode.
//
// Functional notes
// - Set bit clocks and enables its unit.
// - Clear bit: unit off, access faults.
// - Register resets to all zero.
// - Run, sleep, deep sets per mode.
// - Sleep and deep sets need auto gating select.
// - Comparators two..zero at bits 26..24.
// - Serial ports one, zero at bits 1, 0.
// - Reserved bits read zero, ignore writes.
// - Deep register decoded at offset 0x124.
`timescale 1ns/100ps
`default_nettype none
module dsg_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire dsg_pkg::dsg_pm_e power_mode,
	input wire logic [31:0] unit_access,
	output logic [31:0] unit_clk_en,
	output logic [31:0] unit_fault
);

	////////////////////////////////////////////////////////////////////
	// Address phase capture.

	dsg_pkg::dsg_aphase_s aph_d;
	dsg_pkg::dsg_aphase_s aph_q;

	// Only whole-word NONSEQ and SEQ transfers are taken; others are idle.
	always_comb begin
		aph_d.valid = hsel && hready && htrans[1] && (hsize == 3'h2);
		aph_d.write = hwrite;
		aph_d.offset = haddr[11:0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aph_q <= '0;
		end else begin
			aph_q <= aph_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register file.

	logic [31:0] run_gate_reg_one_q, run_gate_reg_one_d;
	logic [31:0] sleep_gate_reg_one_q, sleep_gate_reg_one_d;
	logic [31:0] deep_sleep_gate_reg_one_q, deep_sleep_gate_reg_one_d;
	logic [31:0] run_clock_config_reg_q, run_clock_config_reg_d;
	logic [31:0] hrdata_d;

	// Keeps only implemented bits so reserved bits stay zero.
	function automatic logic [31:0] dsg_keep(input logic [31:0] v, input logic [31:0] m);
		dsg_keep = v & m;
	endfunction

	// Write decode in the data phase; reads return the stored value.
	always_comb begin
		run_gate_reg_one_d = run_gate_reg_one_q;
		sleep_gate_reg_one_d = sleep_gate_reg_one_q;
		deep_sleep_gate_reg_one_d = deep_sleep_gate_reg_one_q;
		run_clock_config_reg_d = run_clock_config_reg_q;
		hrdata_d = 32'h00000000;
		if (aph_q.valid && aph_q.write) begin
			unique case (aph_q.offset)
				dsg_pkg::DSG_OFF_RUN:
					run_gate_reg_one_d = dsg_keep(hwdata, dsg_pkg::DSG_GATE_MASK);
				dsg_pkg::DSG_OFF_SLEEP:
					sleep_gate_reg_one_d = dsg_keep(hwdata, dsg_pkg::DSG_GATE_MASK);
				dsg_pkg::DSG_OFF_DEEP:
					deep_sleep_gate_reg_one_d = dsg_keep(hwdata, dsg_pkg::DSG_GATE_MASK);
				dsg_pkg::DSG_OFF_MODE:
					run_clock_config_reg_d = dsg_keep(hwdata, dsg_pkg::DSG_MODE_MASK);
				default: ;
			endcase
		end
		// Read data is prepared from the address phase so it stands in the data phase.
		if (aph_d.valid && !aph_d.write) begin
			unique case (aph_d.offset)
				dsg_pkg::DSG_OFF_RUN: hrdata_d = run_gate_reg_one_d;
				dsg_pkg::DSG_OFF_SLEEP: hrdata_d = sleep_gate_reg_one_d;
				dsg_pkg::DSG_OFF_DEEP: hrdata_d = deep_sleep_gate_reg_one_d;
				dsg_pkg::DSG_OFF_MODE: hrdata_d = run_clock_config_reg_d;
				default: hrdata_d = 32'h00000000;
			endcase
		end
	end

	// Gate bits 26..24, 18..16, 12, 8, 4, 2..0 and mode bit 27 are the only register storage.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_gate_reg_one_q <= dsg_pkg::DSG_GATE_RESET;
			sleep_gate_reg_one_q <= dsg_pkg::DSG_GATE_RESET;
			deep_sleep_gate_reg_one_q <= dsg_pkg::DSG_GATE_RESET;
			run_clock_config_reg_q <= 32'h00000000;
			hrdata <= 32'h00000000;
		end else begin
			run_gate_reg_one_q <= run_gate_reg_one_d;
			sleep_gate_reg_one_q <= sleep_gate_reg_one_d;
			deep_sleep_gate_reg_one_q <= deep_sleep_gate_reg_one_d;
			run_clock_config_reg_q <= run_clock_config_reg_d;
			hrdata <= hrdata_d;
		end
	end

	// Zero-wait slave: every transfer completes OKAY in one data cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Gate set selection and unit enables.

	logic [31:0] gate_sel;
	logic [31:0] unit_clk_en_d;
	logic [31:0] unit_fault_d;

	dsg_gate_sel u_sel (
		.auto_gating_select(run_clock_config_reg_q[dsg_pkg::DSG_BIT_AUTO]),
		.mode(power_mode),
		.run_gate(run_gate_reg_one_q),
		.sleep_gate(sleep_gate_reg_one_q),
		.deep_gate(deep_sleep_gate_reg_one_q),
		.gate(gate_sel)
	);

	// A gated-off unit that sees an access raises a fault one cycle later, held while the access lasts.
	// Enables are registered, so a new setting reaches units one cycle late.
	always_comb begin
		unit_clk_en_d = gate_sel & dsg_pkg::DSG_GATE_MASK;
		unit_fault_d = unit_access & ~unit_clk_en_d & dsg_pkg::DSG_GATE_MASK;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			unit_clk_en <= 32'h00000000;
			unit_fault <= 32'h00000000;
		end else begin
			unit_clk_en <= unit_clk_en_d;
			unit_fault <= unit_fault_d;
		end
	end

endmodule
`default_nettype wire

// [test/dsg_properties.sv]
// Checker on the gating block ports.
// Assumes hready is hreadyout looped back.
`timescale 1ns/100ps
`default_nettype none
module dsg_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire dsg_pkg::dsg_pm_e power_mode,
	input wire logic [31:0] unit_access,
	input wire logic [31:0] unit_clk_en,
	input wire logic [31:0] unit_fault
);
	// Taken address phases; f8f8eee8 is every reserved bit.
	wire logic rd = hsel && hreadyout && htrans[1] && !hwrite;
	wire logic wr = hsel && hreadyout && htrans[1] && hwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bad answer");
	property p_idle; !$past(rd) |-> hrdata == '0; endproperty
	a_idle: assert property (p_idle) else $error("stray data");
	property p_unmap; rd && haddr[11:0] == 12'h200 |=> hrdata == '0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_resv; rd && haddr[11:0] == 12'h124 |=> (hrdata & 32'hf8f8eee8) == '0; endproperty
	a_resv: assert property (p_resv) else $error("reserved read");
	property p_mask; (unit_clk_en & 32'hf8f8eee8) == '0; endproperty
	a_mask: assert property (p_mask) else $error("reserved enable");
	property p_init; $fell(rst) |-> unit_clk_en == '0 && unit_fault == '0; endproperty
	a_init: assert property (p_init) else $error("reset state");
	// Reserved access bits never fault, since no unit sits behind them.
	property p_fault; unit_fault == ($past(unit_access) & ~unit_clk_en & 32'h07071117);
	endproperty
	a_fault: assert property (p_fault) else $error("bad fault");
	// An enable may only move after a write or a change of power mode.
	property p_cause; !$stable(unit_clk_en) |-> $past(wr, 2) || $past(wr, 3)
		|| $past(power_mode) != $past(power_mode, 2) || $past(power_mode, 2) != $past(power_mode, 3);
	endproperty
	a_cause: assert property (p_cause) else $error("enable moved");
	c_fault: cover property (unit_fault != '0);
	c_en: cover property (unit_clk_en != '0);
	c_rd: cover property (rd && haddr[11:0] == 12'h124);
endmodule
bind dsg_top dsg_properties u_chk (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.power_mode(power_mode), .unit_access(unit_access), .unit_clk_en(unit_clk_en),
	.unit_fault(unit_fault));
`default_nettype wire

// [test/tb.sv]
// Bench: bus tasks, a register model keyed by offset, random traffic.
// Assumes hready is the slave's hreadyout looped back.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rdy_q;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, unit_access = '0, rnd = 32'h00002630;
	logic [31:0] hrdata, unit_clk_en, unit_fault, rd_q, rdv;
	logic hreadyout, hresp;
	logic [31:0] m[logic [11:0]];
	dsg_pkg::dsg_pm_e power_mode = dsg_pkg::DSG_PM_RUN;
	int n_fail = 0, n_compared = 0, cyc = 0;
	// Clock, edge samples of the answer, and a ceiling against hangs.
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		rd_q <= hrdata;
		rdy_q <= hreadyout;
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	dsg_top dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_mode(power_mode),
		.unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Set that the model says drives the units; auto select is bit 27 of 0x060.
	function automatic logic [31:0] ex();
		if (!m[12'h060][27] || power_mode == dsg_pkg::DSG_PM_RUN) return m[12'h104];
		return (power_mode == dsg_pkg::DSG_PM_SLEEP) ? m[12'h114] : m[12'h124];
	endfunction
	// One single word transfer; both phases wait on the ready sampled at the edge.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= dsg_pkg::DSG_BASE + a;
		do begin @(posedge clk_sys); #1; end while (rdy_q !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk_sys); #1; end while (rdy_q !== 1'b1);
		// The select stays up with an idle transfer; a next call sets it high again.
		rdv = rd_q;
	endtask
	// Optional write, then read back against the model.
	task automatic rw(input logic [11:0] a, input logic [31:0] d, input logic w);
		if (w) bus(1'b1, a, d);
		if (w && m.exists(a)) m[a] = d & ((a == 12'h060) ? 32'h08000000 : 32'h07071117);
		bus(1'b0, a, '0);
		`CHK("rdata", (m.exists(a) ? m[a] : 32'h0), rdv)
	endtask
	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Reset values, each deep bit alone, an unmapped place, then random sets per mode.
	initial begin
		m[12'h104] = '0;
		m[12'h114] = '0;
		m[12'h124] = '0;
		m[12'h060] = '0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		foreach (m[a]) rw(a, '0, 1'b0);
		for (int i = 0; i < 32; i++) rw(12'h124, 32'h1 << i, 1'b1);
		rw(12'h200, '1, 1'b1);
		repeat (12) begin
			foreach (m[a]) begin
				rnd = xs(rnd);
				rw(a, rnd, 1'b1);
			end
			for (int k = 0; k < 3; k++) begin
				power_mode <= dsg_pkg::dsg_pm_e'(3'h1 << k);
				rnd = xs(rnd);
				unit_access <= rnd;
				repeat (4) @(posedge clk_sys);
				#1;
				`CHK("clk_en", ex(), unit_clk_en)
				`CHK("fault", unit_access & ~ex() & dsg_pkg::DSG_GATE_MASK, unit_fault)
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
